// ### dsac_pkg.sv
// constants, types and the stream recombination shared by both ends
// assumes a single core clock; the bit clock is made from it by a divider
package dsac_pkg;

    // modulator clock divider: bit clock is core clock / 4, high in the last two phases
    localparam logic [1:0]  DSAC_DIV_LAST     = 2'h3;
    localparam logic [1:0]  DSAC_CLK_HIGH_AT  = 2'h2;

    // filter selection codes
    typedef enum logic [1:0] {
        DSAC_FSEL_BYPASS = 2'b00,
        DSAC_FSEL_SINC   = 2'b01,
        DSAC_FSEL_FIR    = 2'b10,
        DSAC_FSEL_HPF    = 2'b11
    } dsac_fsel_e;

    // decimation: sinc ratio is 128 >> rate, rate 0..4
    localparam logic [2:0]  DSAC_RATE_MAX     = 3'h4;
    localparam logic [6:0]  DSAC_SINC_LAST    = 7'h7f;
    localparam int          DSAC_CIC_ORDER    = 5;
    localparam int          DSAC_CIC_W        = 48;
    localparam int          DSAC_Y_W          = 8;
    localparam logic [4:0]  DSAC_FIR_LAST     = 5'h1f;
    localparam int          DSAC_FIR_SHIFT    = 5;
    localparam int          DSAC_HPF_FRAC     = 16;
    localparam int          DSAC_GAIN_FRAC    = 23;

    // configuration defaults
    localparam logic [1:0]  DSAC_DEF_FSEL     = 2'h2;
    localparam logic [2:0]  DSAC_DEF_RATE     = 3'h2;
    localparam logic        DSAC_DEF_WORD32   = 1'b1;
    localparam logic [3:0]  DSAC_DEF_HPF_SH   = 4'h8;
    localparam logic [23:0] DSAC_DEF_GAIN     = 24'h800000;
    localparam logic [31:0] DSAC_DEF_OFFSET   = 32'h00000000;

    // recombination weights
    localparam logic signed [7:0] DSAC_K_A2 = 8'sh03;
    localparam logic signed [7:0] DSAC_K_A3 = 8'sh06;
    localparam logic signed [7:0] DSAC_K_A4 = 8'sh04;
    localparam logic signed [7:0] DSAC_K_B  = 8'sh09;

    typedef logic signed [DSAC_Y_W-1:0] dsac_y_t;

    // 3a[n-2] - 6a[n-3] + 4a[n-4] + 9(b[n] - 2b[n-1] + b[n-2]), bits taken as 0/1
    function automatic dsac_y_t dsac_recombine(input logic a2, input logic a3,
                                               input logic a4, input logic b0,
                                               input logic b1, input logic b2);
        dsac_y_t s;
        s = (a2 ? DSAC_K_A2 : 8'sh00) - (a3 ? DSAC_K_A3 : 8'sh00)
          + (a4 ? DSAC_K_A4 : 8'sh00) + (b0 ? DSAC_K_B : 8'sh00)
          - (b1 ? (DSAC_K_B <<< 1) : 8'sh00) + (b2 ? DSAC_K_B : 8'sh00);
        return s;
    endfunction

endpackage

// ### dsac_link_if.sv
// bitstream link between converter core and external filter logic
// the core drives every signal; the bit clock is a divided core clock
`timescale 1ns/1ps
interface dsac_link_if;
    logic bit_clk;
    logic first_stage_bit;
    logic second_stage_bit;
    logic overrange_flag;

    modport dev (output bit_clk, output first_stage_bit, output second_stage_bit,
                 output overrange_flag);
    modport ext (input bit_clk, input first_stage_bit, input second_stage_bit,
                 input overrange_flag);
endinterface

// ### dsac_sync2.sv
// two flip-flop level synchroniser, width W
// assumes each bit is a slow level; multi-bit words must be stable while sampled
`timescale 1ns/1ps
module dsac_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // level in and out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else
        begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;
endmodule // dsac_sync2

// ### dsac_core.sv
// converter control core: modulator pacing, filter chain, scaling, control inputs
// assumes modulator bits and comparator come from the analog model asynchronously
`timescale 1ns/1ps
module dsac_core
    import dsac_pkg::*;
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // control pins
    input  wire logic        i_control_mode_select,
    input  wire logic        i_pin_bypass,
    input  wire logic        i_pin_hpf,
    input  wire logic [1:0]  i_pin_rate,
    input  wire logic        i_reset_pin_n,
    input  wire logic        i_align,
    input  wire logic        i_power_down_input_n,
    // analog modulator model
    input  wire logic        i_mod_first,
    input  wire logic        i_mod_second,
    input  wire logic        i_overrange_cmp,
    // decoded serial port commands
    input  wire logic        i_cfg_write,
    input  wire logic [1:0]  i_cfg_filter_select,
    input  wire logic [2:0]  i_cfg_rate,
    input  wire logic        i_cfg_word32,
    input  wire logic [3:0]  i_cfg_hpf_shift,
    input  wire logic [23:0] i_cfg_gain,
    input  wire logic [31:0] i_cfg_offset,
    input  wire logic        i_standby_cmd,
    input  wire logic        i_wakeup_cmd,
    // result and readback
    output logic [31:0]      o_result,
    output logic             o_result_valid,
    output logic             o_standby,
    output logic [1:0]       o_filter_select_field,
    output logic [2:0]       o_rate,
    // bitstream link
    dsac_link_if.dev         link
);
    logic [9:0] pins_q;
    // pin qualification
    // pins pass two core-clock flops before use
    dsac_sync2 #(.W(10)) u_sync (
        .i_clk (i_mclk),
        .i_rst (i_rst),
        .i_d   ({i_reset_pin_n, i_align, i_power_down_input_n, i_mod_first,
                 i_mod_second, i_overrange_cmp, i_pin_bypass, i_pin_hpf, i_pin_rate}),
        .o_q   (pins_q)
    );
    wire        rst_pin_n_s = pins_q[9];
    wire        align_s     = pins_q[8];
    wire        pdn_n_s     = pins_q[7];
    wire        a_new       = pins_q[6];
    wire        b_new       = pins_q[5];
    wire        ovr_s       = pins_q[4];
    wire        pbyp_s      = pins_q[3];
    wire        phpf_s      = pins_q[2];
    wire [1:0]  prate_s     = pins_q[1:0];

    logic        align_d_reg;
    logic [1:0]  fsel_reg;
    logic [2:0]  rate_reg;
    logic        word32_reg;
    logic [3:0]  hsh_reg;
    logic [23:0] gain_reg;
    logic [31:0] offset_reg;
    logic        standby_reg;

    // mode strap is a pin as well; qualify it like the rest
    logic mode_q;
    dsac_sync2 #(.W(1)) u_sync_mode (
        .i_clk (i_mclk),
        .i_rst (i_rst),
        .i_d   (i_control_mode_select),
        .o_q   (mode_q)
    );
    wire power_off = ~pdn_n_s;
    wire pin_mode  = mode_q;
    wire cfg_clear = power_off | (~rst_pin_n_s & ~pin_mode);

    // settings written only in register mode
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            {fsel_reg, rate_reg, word32_reg} <= {DSAC_DEF_FSEL, DSAC_DEF_RATE, DSAC_DEF_WORD32};
            {hsh_reg, gain_reg, offset_reg}  <= {DSAC_DEF_HPF_SH, DSAC_DEF_GAIN, DSAC_DEF_OFFSET};
        end
        else if (cfg_clear)
        begin
            {fsel_reg, rate_reg, word32_reg} <= {DSAC_DEF_FSEL, DSAC_DEF_RATE, DSAC_DEF_WORD32};
            {hsh_reg, gain_reg, offset_reg}  <= {DSAC_DEF_HPF_SH, DSAC_DEF_GAIN, DSAC_DEF_OFFSET};
        end
        else if (i_cfg_write & ~pin_mode)
        begin
            {fsel_reg, rate_reg, word32_reg} <= {i_cfg_filter_select, i_cfg_rate, i_cfg_word32};
            {hsh_reg, gain_reg, offset_reg}  <= {i_cfg_hpf_shift, i_cfg_gain, i_cfg_offset};
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            standby_reg <= 1'b0;
        else if (power_off | ~rst_pin_n_s)
            standby_reg <= 1'b0;
        else if (i_standby_cmd)
            standby_reg <= 1'b1;
        else if (i_wakeup_cmd)
            standby_reg <= 1'b0;
    end

    wire [1:0] pin_fsel  = pbyp_s ? DSAC_FSEL_BYPASS : (phpf_s ? DSAC_FSEL_HPF : DSAC_FSEL_FIR);
    wire [1:0] fsel_eff  = pin_mode ? pin_fsel : fsel_reg;
    wire [2:0] rate_clip = (rate_reg > DSAC_RATE_MAX) ? DSAC_RATE_MAX : rate_reg;
    wire [2:0] rate_eff  = pin_mode ? {1'b0, prate_s} : rate_clip;
    wire       bypass    = (fsel_eff == DSAC_FSEL_BYPASS);

    logic [1:0] div_reg;
    logic [6:0] sinc_cnt_reg;
    logic [4:0] fir_cnt_reg;
    wire frame_start = (div_reg == 2'h0) & (sinc_cnt_reg == 7'h00) & (fir_cnt_reg == 5'h00);
    wire align_rise  = align_s & ~align_d_reg;
    // a locked frame clock landing on a frame start does not disturb
    wire restart     = power_off | standby_reg | ~rst_pin_n_s | (align_rise & ~frame_start);

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            align_d_reg <= 1'b0;
        else
            align_d_reg <= align_s;
    end

    // divide by four, bits change as bit clock falls
    wire [1:0] div_next = restart ? 2'h0 : div_reg + 2'h1;
    wire       tick     = ~restart & (div_reg == DSAC_DIV_LAST);

    logic [3:0] hist_a_reg;
    logic [1:0] hist_b_reg;
    logic       bit_clk_reg;
    logic       first_reg;
    logic       second_reg;
    logic       half_reg;
    logic       flag_reg;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_reg     <= 2'h0;
            bit_clk_reg <= 1'b0;
        end
        else
        begin
            div_reg     <= div_next;
            // bit clock only runs in raw mode
            bit_clk_reg <= bypass & ~restart & (div_next >= DSAC_CLK_HIGH_AT);
        end
    end

    // raw bits driven on the link
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            {first_reg, second_reg} <= 2'b00;
        else if (restart | ~bypass)
            {first_reg, second_reg} <= 2'b00;
        else if (tick)
            {first_reg, second_reg} <= {a_new, b_new};
    end

    // flag sampled every second modulator cycle
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            {half_reg, flag_reg} <= 2'b00;
        else if (power_off)
            {half_reg, flag_reg} <= 2'b00;
        else if (tick)
        begin
            half_reg <= ~half_reg;
            if (half_reg)
                flag_reg <= ovr_s;
        end
    end

    wire     filt_run = tick & ~bypass;
    dsac_y_t y_now;
    assign y_now = dsac_recombine(hist_a_reg[1], hist_a_reg[2], hist_a_reg[3],
                                  b_new, hist_b_reg[0], hist_b_reg[1]);

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            {hist_a_reg, hist_b_reg} <= 6'h00;
        else if (restart)
            {hist_a_reg, hist_b_reg} <= 6'h00;
        else if (tick)
            {hist_a_reg, hist_b_reg} <= {hist_a_reg[2:0], a_new, hist_b_reg[0], b_new};
    end

    // fifth-order sinc: integrators at modulator rate, combs at decimated rate
    logic signed [DSAC_CIC_W-1:0] integ_reg [DSAC_CIC_ORDER];
    logic signed [DSAC_CIC_W-1:0] combd_reg [DSAC_CIC_ORDER];
    logic signed [DSAC_CIC_W-1:0] comb_in   [DSAC_CIC_ORDER+1];
    logic signed [31:0]           sinc_out_reg;
    logic                         sinc_vld_reg;
    wire        sinc_dump = filt_run & (sinc_cnt_reg == (DSAC_SINC_LAST >> rate_eff));
    wire [5:0]  norm_sh   = {1'b0, rate_eff, 2'b00} + {3'h0, rate_eff};
    wire signed [DSAC_CIC_W-1:0] sinc_norm = comb_in[DSAC_CIC_ORDER] <<< norm_sh;

    always_comb
    begin
        comb_in[0] = integ_reg[DSAC_CIC_ORDER-1];
        for (int k = 0; k < DSAC_CIC_ORDER; k++)
            comb_in[k+1] = comb_in[k] - combd_reg[k];
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < DSAC_CIC_ORDER; k++)
                {integ_reg[k], combd_reg[k]} <= '0;
        end
        else if (restart)
        begin
            for (int k = 0; k < DSAC_CIC_ORDER; k++)
                {integ_reg[k], combd_reg[k]} <= '0;
        end
        else
        begin
            if (filt_run)
            begin
                integ_reg[0] <= integ_reg[0] + DSAC_CIC_W'(y_now);
                for (int k = 1; k < DSAC_CIC_ORDER; k++)
                    integ_reg[k] <= integ_reg[k] + integ_reg[k-1];
            end
            if (sinc_dump)
            begin
                for (int k = 0; k < DSAC_CIC_ORDER; k++)
                    combd_reg[k] <= comb_in[k];
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sinc_cnt_reg <= 7'h00;
            sinc_out_reg <= 32'sh0;
            sinc_vld_reg <= 1'b0;
        end
        else if (restart)
        begin
            sinc_cnt_reg <= 7'h00;
            sinc_out_reg <= 32'sh0;
            sinc_vld_reg <= 1'b0;
        end
        else
        begin
            if (filt_run)
                sinc_cnt_reg <= sinc_dump ? 7'h00 : sinc_cnt_reg + 7'h01;
            if (sinc_dump)
                sinc_out_reg <= sinc_norm[DSAC_CIC_W-1:DSAC_CIC_W-32];
            sinc_vld_reg <= sinc_dump;
        end
    end

    // decimate-by-32 low-pass, equal taps; phase option not modelled
    logic signed [36:0] fir_acc_reg;
    logic signed [31:0] fir_out_reg;
    logic               fir_vld_reg;
    wire signed [36:0]  fir_sum = fir_acc_reg + 37'(sinc_out_reg);
    wire signed [36:0]  fir_avg = fir_sum >>> DSAC_FIR_SHIFT;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            {fir_cnt_reg, fir_acc_reg, fir_out_reg, fir_vld_reg} <= '0;
        end
        else if (restart)
        begin
            {fir_cnt_reg, fir_acc_reg, fir_out_reg, fir_vld_reg} <= '0;
        end
        else
        begin
            fir_vld_reg <= sinc_vld_reg & (fir_cnt_reg == DSAC_FIR_LAST);
            if (sinc_vld_reg)
            begin
                fir_cnt_reg <= fir_cnt_reg + 5'h01;
                fir_acc_reg <= (fir_cnt_reg == DSAC_FIR_LAST) ? 37'sh0 : fir_sum;
                if (fir_cnt_reg == DSAC_FIR_LAST)
                    fir_out_reg <= fir_avg[31:0];
            end
        end
    end

    logic signed [47:0] dc_reg;
    logic signed [31:0] hpf_out_reg;
    logic               hpf_vld_reg;
    wire signed [31:0]  hp_now  = fir_out_reg - dc_reg[47:DSAC_HPF_FRAC];
    // signed view so a negative step keeps its sign through the shift
    wire signed [47:0]  dc_step = $signed({hp_now, 16'h0000}) >>> hsh_reg;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            {dc_reg, hpf_out_reg, hpf_vld_reg} <= '0;
        else if (restart)
            {dc_reg, hpf_out_reg, hpf_vld_reg} <= '0;
        else
        begin
            hpf_vld_reg <= fir_vld_reg;
            if (fir_vld_reg)
            begin
                dc_reg      <= dc_reg + dc_step;
                hpf_out_reg <= hp_now;
            end
        end
    end

    wire signed [31:0] tap = (fsel_eff == DSAC_FSEL_SINC) ? sinc_out_reg :
                             (fsel_eff == DSAC_FSEL_FIR)  ? fir_out_reg  : hpf_out_reg;
    wire tap_vld = (fsel_eff == DSAC_FSEL_SINC) ? sinc_vld_reg :
                   (fsel_eff == DSAC_FSEL_FIR)  ? fir_vld_reg  :
                   (fsel_eff == DSAC_FSEL_HPF)  ? hpf_vld_reg  : 1'b0;
    // offset then gain, gain 1.0 at 2^23
    wire signed [63:0] prod   = 64'(tap - $signed(offset_reg)) * 64'($signed({1'b0, gain_reg}));
    wire signed [63:0] scaled = prod >>> DSAC_GAIN_FRAC;

    logic [31:0] result_reg;
    logic        result_vld_reg;
    // recovery time is the chain latency alone, no extra holdoff
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            {result_reg, result_vld_reg} <= '0;
        else
        begin
            result_vld_reg <= tap_vld & ~restart;
            // 24-bit word zeroes the low byte
            if (tap_vld)
                result_reg <= word32_reg ? scaled[31:0] : {scaled[31:8], 8'h00};
        end
    end

    logic [4:0] status_reg;
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            status_reg <= '0;
        else
            status_reg <= {fsel_eff, rate_eff};
    end

    assign o_result              = result_reg;
    assign o_result_valid        = result_vld_reg;
    assign o_standby             = standby_reg;
    assign o_filter_select_field = status_reg[4:3];
    assign o_rate                = status_reg[2:0];
    assign link.bit_clk          = bit_clk_reg;
    assign link.first_stage_bit  = first_reg;
    assign link.second_stage_bit = second_reg;
    assign link.overrange_flag   = flag_reg;
endmodule // dsac_core

// ### dsac_ext_filter.sv
// external logic that takes the raw bitstream and rebuilds the combined sample
// assumes the bit clock runs only in raw mode and may stop between frames
`timescale 1ns/1ps
module dsac_ext_filter
    import dsac_pkg::*;
(
    // clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_rst,
    // bitstream link
    dsac_link_if.ext   link,
    // combined samples and flag, core clock domain
    output dsac_y_t    o_sample,
    output logic       o_sample_valid,
    output logic       o_overrange
);
    logic [3:0] a_reg;
    logic [1:0] b_reg;
    logic [2:0] fill_reg;
    dsac_y_t    hold_reg;
    logic       req_reg;
    logic       ack_l;

    // bits registered on the bit clock, first stage four deep, second stage two deep
    always_ff @(posedge link.bit_clk or posedge i_rst)
    begin
        if (i_rst)
            {a_reg, b_reg, fill_reg} <= '0;
        else
        begin
            a_reg <= {a_reg[2:0], link.first_stage_bit};
            b_reg <= {b_reg[0], link.second_stage_bit};
            if (fill_reg != 3'h4)
                fill_reg <= fill_reg + 3'h1;
        end
    end

    // sample taken only when the previous one was accepted
    always_ff @(posedge link.bit_clk or posedge i_rst)
    begin
        if (i_rst)
            {hold_reg, req_reg} <= '0;
        else if ((fill_reg == 3'h4) & (req_reg == ack_l))
        begin
            // the bit pair arriving now is index n for both stages
            hold_reg <= dsac_recombine(a_reg[1], a_reg[2], a_reg[3],
                                       link.second_stage_bit, b_reg[0], b_reg[1]);
            req_reg  <= ~req_reg;
        end
    end

    logic       ack_reg;
    logic [1:0] m_q;
    dsac_sync2 #(.W(1)) u_ack (
        .i_clk (link.bit_clk),
        .i_rst (i_rst),
        .i_d   (ack_reg),
        .o_q   (ack_l)
    );
    dsac_sync2 #(.W(2)) u_req (
        .i_clk (i_mclk),
        .i_rst (i_rst),
        .i_d   ({req_reg, link.overrange_flag}),
        .o_q   (m_q)
    );

    dsac_y_t sample_reg;
    logic    valid_reg;
    logic    ovr_reg;
    // hold word is stable while the request toggle is in flight
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            {ack_reg, sample_reg, valid_reg, ovr_reg} <= '0;
        else
        begin
            valid_reg <= (m_q[1] != ack_reg);
            ovr_reg   <= m_q[0];
            if (m_q[1] != ack_reg)
            begin
                sample_reg <= hold_reg;
                ack_reg    <= m_q[1];
            end
        end
    end

    assign o_sample       = sample_reg;
    assign o_sample_valid = valid_reg;
    assign o_overrange    = ovr_reg;
endmodule // dsac_ext_filter

// ### dsac_link_monitor.sv
// checks on the bitstream link: bit clock shape, bit pacing, flag widths
// link signals come in plainly; core clock and reset beside them
`timescale 1ns/1ps
module dsac_link_monitor (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // link signals
    input wire logic bit_clk,
    input wire logic first_stage_bit,
    input wire logic second_stage_bit,
    input wire logic overrange_flag
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire logic [1:0] bits = {first_stage_bit, second_stage_bit};

    chk_clk_high_two: assert property ($rose(bit_clk) |=> bit_clk ##1 !bit_clk)
        else $error("bit clock high time wrong");
    chk_clk_period: assert property ($rose(bit_clk) |=> !$rose(bit_clk) [*3])
        else $error("bit clock period short");
    chk_clk_low_lead: assert property ($rose(bit_clk) |-> !$past(bit_clk, 2))
        else $error("bit clock low time short");
    chk_bits_hold_high: assert property (bit_clk |-> $stable(bits))
        else $error("bits moved while bit clock high");
    chk_bits_once: assert property ($changed(bits) |=> $stable(bits) [*3])
        else $error("bits moved twice in one bit clock");
    chk_bits_idle_zero: assert property (!bit_clk [*8] |-> bits == 2'h0)
        else $error("bits driven outside raw mode");
    chk_flag_high_min: assert property ($rose(overrange_flag) |-> overrange_flag [*8])
        else $error("flag high pulse short");
    chk_flag_low_min: assert property ($fell(overrange_flag) |-> !overrange_flag [*8])
        else $error("flag low gap short");
    cov_bit_clk: cover property ($rose(bit_clk));
    cov_bits: cover property ($changed(bits));
    cov_flag: cover property ($rose(overrange_flag));
endmodule // dsac_link_monitor

// ### delta_sigma_adc_control_core_bench.sv
// bench: core and external filter joined by the link, driven at the ports
// assumes one core clock; the core makes the bit clock itself
`timescale 1ns/1ps
module delta_sigma_adc_control_core_bench;
    import dsac_pkg::*;
    logic        clk, rst, mode, byp, hpf, algn, rst_n, pwd_n, ma, mb, cmp;
    logic        wr, stby, wake, w32, rv, sv, sb, eor;
    logic [1:0]  prate, fs, fso;
    logic [2:0]  rt, rto;
    logic [23:0] gn;
    logic [31:0] off, res;
    dsac_y_t     smp;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          k;
    dsac_link_if lnk ();
    dsac_core i_dsac_core (.i_mclk(clk), .i_rst(rst), .i_control_mode_select(mode),
        .i_pin_bypass(byp), .i_pin_hpf(hpf), .i_pin_rate(prate), .i_reset_pin_n(rst_n),
        .i_align(algn), .i_power_down_input_n(pwd_n), .i_mod_first(ma), .i_mod_second(mb),
        .i_overrange_cmp(cmp), .i_cfg_write(wr), .i_cfg_filter_select(fs), .i_cfg_rate(rt),
        .i_cfg_word32(w32), .i_cfg_hpf_shift(4'h8), .i_cfg_gain(gn), .i_cfg_offset(off),
        .i_standby_cmd(stby), .i_wakeup_cmd(wake), .o_result(res), .o_result_valid(rv),
        .o_standby(sb), .o_filter_select_field(fso), .o_rate(rto), .link(lnk.dev));
    dsac_ext_filter i_dsac_ext_filter (.i_mclk(clk), .i_rst(rst), .link(lnk.ext),
        .o_sample(smp), .o_sample_valid(sv), .o_overrange(eor));
    dsac_link_monitor i_dsac_link_monitor (.i_mclk(clk), .i_rst(rst), .bit_clk(lnk.bit_clk),
        .first_stage_bit(lnk.first_stage_bit), .second_stage_bit(lnk.second_stage_bit),
        .overrange_flag(lnk.overrange_flag));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // bounded wait; a pulse is seen one step after its edge
    task automatic wait_hi(ref logic s, input int lim);
        for (k = 0; k < lim && s !== 1'b1; k++)
            tick(1);
        if (s !== 1'b1)
        begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic quiet(input int n);
        int hits = 0;
        repeat (n)
        begin
            tick(1);
            hits += (rv === 1'b1);
        end
        chk(hits, 0);
    endtask
    task automatic cfg(input logic [1:0] f, input logic [2:0] r, input logic w,
                       input logic [31:0] o);
        fs = f;
        rt = r;
        w32 = w;
        off = o;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(2);
    endtask
    // level pins are held for n cycles, then let settle through the synchroniser
    task automatic pulse(ref logic s, input int n);
        s = ~s;
        tick(n);
        s = ~s;
        tick(4);
    endtask
    initial
    begin
        {rst, mode, byp, hpf, algn, rst_n, pwd_n, ma, mb, cmp, wr, stby, wake, w32} = 14'h21c0;
        {prate, fs, rt, gn, off} = '0;
        gn = DSAC_DEF_GAIN;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        tick(4);
        chk(fso, DSAC_DEF_FSEL);
        for (int f = 1; f < 4; f++)
        begin
            cfg(f[1:0], 3'h7, 1'b1, 32'h0);
            chk(fso, f);
            chk(rto, 3'h4);
        end
        // steady first-stage ones give y = 1, a settled sinc tap of 1 << 19;
        // unity gain leaves tap minus offset once a dozen outputs have passed
        cfg(DSAC_FSEL_SINC, 3'h4, 1'b1, 32'h12345678);
        repeat (12)
        begin
            wait_hi(rv, 100);
            tick(1);
        end
        wait_hi(rv, 100);
        chk(res, 32'hedd3a988);
        cfg(DSAC_FSEL_SINC, 3'h4, 1'b0, 32'h12345678);
        tick(40);
        wait_hi(rv, 100);
        chk(res, 32'hedd3a900);
        tick(10);
        algn = 1'b1;
        quiet(26);
        wait_hi(rv, 60);
        algn = 1'b0;
        cfg(DSAC_FSEL_FIR, 3'h4, 1'b1, 32'h0);
        wait_hi(rv, 1200);
        quiet(1000);
        wait_hi(rv, 100);
        {mode, hpf, prate} = 4'hf;
        tick(6);
        cfg(DSAC_FSEL_SINC, 3'h0, 1'b1, 32'h0);
        chk({fso, rto}, 5'h1b);
        mode = 1'b0;
        tick(6);
        cfg(DSAC_FSEL_SINC, 3'h4, 1'b1, 32'h0);
        pulse(stby, 1);
        chk({sb, fso}, 3'h5);
        quiet(100);
        pulse(wake, 1);
        chk(sb, 1'b0);
        pulse(rst_n, 6);
        chk(fso, DSAC_DEF_FSEL);
        cfg(DSAC_FSEL_SINC, 3'h4, 1'b1, 32'h0);
        pulse(pwd_n, 6);
        chk(fso, DSAC_DEF_FSEL);
        cmp = 1'b1;
        wait_hi(eor, 60);
        cmp = 1'b0;
        tick(40);
        chk(eor, 1'b0);
        cfg(DSAC_FSEL_BYPASS, 3'h4, 1'b1, 32'h0);
        quiet(200);
        // steady bits: the first-stage weights sum to one, the second stage to zero
        repeat (4)
        begin
            tick(1);
            wait_hi(sv, 100);
        end
        chk(32'(smp), 32'h1);
        {ma, mb} = 2'h1;
        repeat (4)
        begin
            tick(1);
            wait_hi(sv, 100);
        end
        chk(32'(smp), 32'h0);
        conclude();
    end
endmodule // delta_sigma_adc_control_core_bench
